/* File: sacs_pkg.sv */
package sacs_pkg;

    // ==========================================================
    // Result word
    localparam int RES_BITS = 10;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [9:0] MSB_INIT = 10'h200;
    localparam logic [3:0] MSB_IDX = 4'h9;
    localparam logic [3:0] LSB_IDX = 4'h0;
    localparam logic [3:0] IDX_STEP = 4'h1;

    // ==========================================================
    // System clock
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;

    // ==========================================================
    // Conversion timing
    localparam int SETTLE_NS = 2000;
    localparam int GUARD_NS = 200;
    localparam int CONV_CLK_MAX_HZ = 550_000;
    localparam int PERIODS_PER_CONV = 11;

    // Least times round up to whole cycles
    localparam int START_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GUARD_CYC = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_PERIOD_CYC = (CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
    localparam int LOW_CYC = (CONV_PERIOD_CYC + 1) / 2;
    localparam int HIGH_CYC = CONV_PERIOD_CYC - LOW_CYC;

    // Counter loads, one less than the cycle count
    localparam logic [5:0] START_CNT = 6'(START_CYC - 1);
    localparam logic [5:0] GUARD_CNT = 6'(GUARD_CYC - 1);
    localparam logic [5:0] LOW_CNT = 6'(LOW_CYC - 1);
    localparam logic [5:0] HIGH_CNT = 6'(HIGH_CYC - 1);
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [5:0] CNT_STEP = 6'h01;
    localparam logic [3:0] PERIODS_LAST = 4'(PERIODS_PER_CONV);
    localparam logic [3:0] PERIOD_FIRST = 4'h1;
    localparam logic [3:0] PERIOD_STEP = 4'h1;

endpackage

/* File: sacs_link_if.sv */
`timescale 1ns/1ps
interface sacs_link_if;
    // Host to device
    logic start;
    logic conv_clk;
    // Device to host
    logic ser_data;
    logic strobe;
    logic status;
    logic [9:0] data;

    modport dev (
        input start,
        input conv_clk,
        output ser_data,
        output strobe,
        output status,
        output data
    );

    modport host (
        output start,
        output conv_clk,
        input ser_data,
        input strobe,
        input status,
        input data
    );
endinterface

/* File: sacs_device.sv */
`timescale 1ns/1ps
// Overview of operation
// - Start loads MSB one, rest zero
// - Only falling conversion clock edges advance
// - Host waits settling time before first fall
// - No falling edge near start trailing edge
// - Start may coincide with low clock pulse
// - Each decided bit serialised with strobe
// - Serial bit valid at strobe rising edge
// - Status high once parallel word valid
// - Straight or offset binary result coding
// - Eleven clock periods, clock within maximum
module sacs_device (
    // System
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // Link to host
    sacs_link_if.dev LINK,
    // Analogue side
    input wire logic COMP_IN,
    output logic [9:0] TRIAL
);

    // ==========================================================
    // Types
    // Idle waits for a start; load holds the top bit trial while start
    // stands and for one cycle after it; conv decides one bit per falling
    // edge; done keeps the finished word until the next start
    // A start restarts the sequence from any state
    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_LOAD = 2'b01,
        D_CONV = 2'b10,
        D_DONE = 2'b11
    } sacs_dev_state_t;

    // ==========================================================
    // Input synchronisers
    // Bit order: comparator, conversion clock, start
    logic [2:0] in_meta_r;
    logic [2:0] in_meta_nxt;
    logic [2:0] in_sync_r;
    logic [2:0] in_sync_nxt;
    // Previous synchronised clock, for the falling edge detector
    logic clk_prev_r;
    logic clk_prev_nxt;
    logic start_s;
    logic clk_s;
    logic comp_s;
    logic clk_fall;

    always_comb begin
        in_meta_nxt = {COMP_IN, LINK.conv_clk, LINK.start};
        in_sync_nxt = in_meta_r;
        clk_prev_nxt = in_sync_r[1];
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            // Idle pin levels: clock high, start and comparator low, so
            // no false falling edge follows reset
            in_meta_r <= 3'h2;
            in_sync_r <= 3'h2;
            clk_prev_r <= 1'b1;
        end else if (CE) begin
            in_meta_r <= in_meta_nxt;
            in_sync_r <= in_sync_nxt;
            clk_prev_r <= clk_prev_nxt;
        end
    end

    // ==========================================================
    // Synchronised inputs and edge detector
    assign start_s = in_sync_r[0];
    assign clk_s = in_sync_r[1];
    assign comp_s = in_sync_r[2];
    // Rising edges are deliberately not detected at all
    // Second against third flip-flop gives one pulse per fall
    assign clk_fall = clk_prev_r & ~clk_s;

    // ==========================================================
    // Approximation sequencer
    sacs_dev_state_t state_r;
    sacs_dev_state_t state_nxt;
    logic [9:0] result_r;
    logic [9:0] result_nxt;
    // Index of the bit on trial, counting down from the top
    logic [3:0] idx_r;
    logic [3:0] idx_nxt;
    logic status_r;
    logic status_nxt;
    // High in the one cycle in which a bit is decided
    logic decided;

    always_comb begin
        state_nxt = state_r;
        result_nxt = result_r;
        idx_nxt = idx_r;
        status_nxt = status_r;
        decided = 1'b0;
        if (start_s) begin
            // Start acts as a restart from any state; falling edges that
            // arrive while start is high, as when start is a low clock
            // pulse of its own length, do nothing, and the first decision
            // waits for the next falling edge after start has ended
            state_nxt = D_LOAD;
            result_nxt = sacs_pkg::MSB_INIT;
            idx_nxt = sacs_pkg::MSB_IDX;
            status_nxt = 1'b0;
        end else begin
            unique case (state_r)
                D_IDLE: begin
                    // Falling edges before any start are ignored
                    state_nxt = D_IDLE;
                end
                D_LOAD: begin
                    // Start has ended; the MSB trial is already on the network
                    // and has settled while start stood
                    state_nxt = D_CONV;
                end
                D_CONV: begin
                    if (clk_fall) begin
                        decided = 1'b1;
                        // Comparator high keeps the trial bit, low clears it
                        result_nxt[idx_r] = comp_s;
                        if (idx_r == sacs_pkg::LSB_IDX) begin
                            state_nxt = D_DONE;
                            status_nxt = 1'b1;
                        end else begin
                            result_nxt[idx_r - sacs_pkg::IDX_STEP] = 1'b1;
                            idx_nxt = idx_r - sacs_pkg::IDX_STEP;
                        end
                    end
                end
                D_DONE: begin
                    // Surplus falling edges of the eleventh period are ignored
                    // until the next start restarts the sequence
                    state_nxt = D_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            // Reset leaves the result cleared and status low
            state_r <= D_IDLE;
            result_r <= sacs_pkg::RESULT_RESET;
            idx_r <= sacs_pkg::MSB_IDX;
            status_r <= 1'b0;
        end else if (CE) begin
            state_r <= state_nxt;
            result_r <= result_nxt;
            idx_r <= idx_nxt;
            status_r <= status_nxt;
        end
    end

    // ==========================================================
    // Serial output and strobe
    logic ser_r;
    logic ser_nxt;
    logic strobe_r;
    logic strobe_nxt;
    // Marks the cycle after a decision, when the strobe is raised
    logic strobe_pend_r;
    logic strobe_pend_nxt;

    always_comb begin
        // The serial bit is the decision just made, held until the next
        // one; the strobe is a single-cycle pulse per decided bit
        ser_nxt = ser_r;
        // Strobe rises one cycle after the bit, so the bit is settled
        strobe_nxt = 1'b0;
        strobe_pend_nxt = decided;
        if (decided) begin
            ser_nxt = comp_s;
        end
        if (strobe_pend_r) begin
            strobe_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ser_r <= 1'b0;
            strobe_r <= 1'b0;
            strobe_pend_r <= 1'b0;
        end else if (CE) begin
            ser_r <= ser_nxt;
            strobe_r <= strobe_nxt;
            strobe_pend_r <= strobe_pend_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // Successive approximation of the input yields straight binary for
    // a unipolar range and offset binary for a bipolar one; the coding
    // is set by the input network, not by the logic
    assign LINK.data = result_r;
    // Status stays high until the next start clears it
    assign LINK.status = status_r;
    assign LINK.ser_data = ser_r;
    assign LINK.strobe = strobe_r;
    // The trial word drives the resistor network and the comparator
    assign TRIAL = result_r;

endmodule

/* File: sacs_host.sv */
`timescale 1ns/1ps
module sacs_host (
    // System
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // User request and results
    input wire logic CONVERT,
    output logic BUSY,
    output logic DONE,
    output logic [9:0] WORD,
    output logic [9:0] SERIAL_WORD,
    // Link to device
    sacs_link_if.host LINK
);

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_GUARD = 3'b010,
        H_LOW = 3'b011,
        H_HIGH = 3'b100,
        H_WAIT = 3'b101
    } sacs_host_state_t;

    // ==========================================================
    // Input synchronisers
    // Bit order: status, strobe, serial data, then parallel word
    logic [12:0] in_meta_r;
    logic [12:0] in_sync_r;
    logic [12:0] in_meta_nxt;
    logic [12:0] in_sync_nxt;
    logic strobe_prev_r;
    logic strobe_prev_nxt;
    logic status_s;
    logic strobe_s;
    logic ser_s;
    logic [9:0] data_s;

    always_comb begin
        in_meta_nxt = {LINK.status, LINK.strobe, LINK.ser_data, LINK.data};
        in_sync_nxt = in_meta_r;
        strobe_prev_nxt = in_sync_r[11];
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            in_meta_r <= 13'h0000;
            in_sync_r <= 13'h0000;
            strobe_prev_r <= 1'b0;
        end else if (CE) begin
            in_meta_r <= in_meta_nxt;
            in_sync_r <= in_sync_nxt;
            strobe_prev_r <= strobe_prev_nxt;
        end
    end

    assign status_s = in_sync_r[12];
    assign strobe_s = in_sync_r[11];
    assign ser_s = in_sync_r[10];
    assign data_s = in_sync_r[9:0];

    // ==========================================================
    // Start and conversion clock sequencer
    sacs_host_state_t state_r;
    sacs_host_state_t state_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [3:0] per_r;
    logic [3:0] per_nxt;
    logic start_r;
    logic start_nxt;
    logic cclk_r;
    logic cclk_nxt;
    logic done_r;
    logic done_nxt;
    logic [9:0] word_r;
    logic [9:0] word_nxt;
    logic [9:0] sword_r;
    logic [9:0] sword_nxt;
    logic cnt_end;

    assign cnt_end = (cnt_r == sacs_pkg::CNT_ZERO);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_end ? cnt_r : cnt_r - sacs_pkg::CNT_STEP;
        per_nxt = per_r;
        start_nxt = start_r;
        cclk_nxt = cclk_r;
        done_nxt = 1'b0;
        word_nxt = word_r;
        sword_nxt = sword_r;
        // Receiver samples at the strobe rising edge
        if (strobe_s && !strobe_prev_r) begin
            sword_nxt = {sword_r[8:0], ser_s};
        end
        unique case (state_r)
            H_IDLE: begin
                if (CONVERT) begin
                    // Clock held high so no falling edge nears the start pulse
                    state_nxt = H_START;
                    start_nxt = 1'b1;
                    cnt_nxt = sacs_pkg::START_CNT;
                    sword_nxt = 10'h000;
                end
            end
            H_START: begin
                if (cnt_end) begin
                    state_nxt = H_GUARD;
                    start_nxt = 1'b0;
                    cnt_nxt = sacs_pkg::GUARD_CNT;
                end
            end
            H_GUARD: begin
                if (cnt_end) begin
                    state_nxt = H_LOW;
                    cclk_nxt = 1'b0;
                    cnt_nxt = sacs_pkg::LOW_CNT;
                    per_nxt = sacs_pkg::PERIOD_FIRST;
                end
            end
            H_LOW: begin
                if (cnt_end) begin
                    state_nxt = H_HIGH;
                    cclk_nxt = 1'b1;
                    cnt_nxt = sacs_pkg::HIGH_CNT;
                end
            end
            H_HIGH: begin
                if (cnt_end) begin
                    if (per_r == sacs_pkg::PERIODS_LAST) begin
                        state_nxt = H_WAIT;
                    end else begin
                        state_nxt = H_LOW;
                        cclk_nxt = 1'b0;
                        cnt_nxt = sacs_pkg::LOW_CNT;
                        per_nxt = per_r + sacs_pkg::PERIOD_STEP;
                    end
                end
            end
            H_WAIT: begin
                if (status_s) begin
                    state_nxt = H_IDLE;
                    word_nxt = data_s;
                    done_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = H_IDLE;
                start_nxt = 1'b0;
                cclk_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= H_IDLE;
            cnt_r <= sacs_pkg::CNT_ZERO;
            per_r <= sacs_pkg::PERIOD_FIRST;
            start_r <= 1'b0;
            cclk_r <= 1'b1;
            done_r <= 1'b0;
            word_r <= sacs_pkg::RESULT_RESET;
            sword_r <= sacs_pkg::RESULT_RESET;
        end else if (CE) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            start_r <= start_nxt;
            cclk_r <= cclk_nxt;
            done_r <= done_nxt;
            word_r <= word_nxt;
            sword_r <= sword_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign LINK.start = start_r;
    assign LINK.conv_clk = cclk_r;
    assign BUSY = (state_r != H_IDLE);
    assign DONE = done_r;
    assign WORD = word_r;
    assign SERIAL_WORD = sword_r;

endmodule

/* File: sacs_link_sva.sv */
`timescale 1ns/1ps
module sacs_link_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Link signals
    input wire logic start,
    input wire logic conv_clk,
    input wire logic ser_data,
    input wire logic strobe,
    input wire logic status,
    input wire logic [9:0] data
);
    // ==========================================================
    // Helper counters
    logic clk_r, stb_r, start_r;
    logic [3:0] stb_cnt_r;
    logic [5:0] per_cnt_r, since_r;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            clk_r <= 1'b1;
            stb_r <= 1'b0;
            start_r <= 1'b0;
            stb_cnt_r <= 4'h0;
            per_cnt_r <= 6'h3F;
            since_r <= 6'h00;
        end else begin
            clk_r <= conv_clk;
            stb_r <= strobe;
            start_r <= start;
            if (start) begin
                stb_cnt_r <= 4'h0;
            end else if (strobe && !stb_r) begin
                stb_cnt_r <= stb_cnt_r + 4'h1;
            end
            if (start) begin
                per_cnt_r <= 6'h3F;
            end else if (!conv_clk && clk_r) begin
                per_cnt_r <= 6'h01;
            end else if (per_cnt_r != 6'h3F) begin
                per_cnt_r <= per_cnt_r + 6'h01;
            end
            if (start && !start_r) begin
                since_r <= 6'h01;
            end else if (since_r != 6'h3F) begin
                since_r <= since_r + 6'h01;
            end
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_msb_load: assert property (
        $rose(start) |-> ##5 (data == sacs_pkg::MSB_INIT && !status))
        else $error("result not loaded with top bit set on start");
    chk_status_start: assert property (
        start && $past(start, 4) |-> !status)
        else $error("status high during start");
    chk_rise_idle: assert property (
        $rose(conv_clk) |=> $stable(data) [*6])
        else $error("rising clock edge changed the result");
    chk_fall_strobe: assert property (
        $fell(conv_clk) && !status |-> ##[3:5] $rose(strobe))
        else $error("falling clock edge gave no strobe");
    chk_strobe_width: assert property (
        $rose(strobe) |=> !strobe)
        else $error("strobe longer than one cycle");
    chk_bit_valid: assert property (
        $rose(strobe) |-> $stable(ser_data))
        else $error("serial bit moved at strobe rise");
    chk_status_after: assert property (
        $rose(status) |-> (stb_cnt_r == 4'h9) ##[1:3] (stb_cnt_r == 4'hA))
        else $error("status not tied to the last bit");
    chk_word_hold: assert property (
        status && $past(status) |-> $stable(data))
        else $error("parallel word moved while valid");
    chk_settle_time: assert property (
        $fell(conv_clk) |-> since_r >= 6'(sacs_pkg::START_CYC))
        else $error("falling edge too soon after start");
    chk_guard_time: assert property (
        $fell(start) |-> conv_clk [*4])
        else $error("falling edge too near start end");
    chk_clk_rate: assert property (
        $fell(conv_clk) |-> per_cnt_r >= 6'(sacs_pkg::CONV_PERIOD_CYC))
        else $error("conversion clock too fast");
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // Signals
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic CE = 1'b1;
    logic CONVERT = 1'b0;
    logic COMP_IN = 1'b0;
    logic BUSY, DONE;
    logic [9:0] WORD, SERIAL_WORD, TRIAL;
    logic [9:0] vin = 10'h000;
    logic [9:0] wire_sh = 10'h000;
    logic stb_q = 1'b0;
    logic clk_q = 1'b1;
    logic [9:0] corners [7] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'h3FE, 10'h001, 10'h297};
    int nstb = 0;
    int nfall = 0;
    int cyc = 0;
    int bad_count = 0;
    int num_checks = 0;

    always #25 CLK = ~CLK;

    sacs_link_if lnk ();
    sacs_device sacs_device_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .LINK(lnk.dev),
        .COMP_IN(COMP_IN), .TRIAL(TRIAL));
    sacs_host sacs_host_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .CONVERT(CONVERT),
        .BUSY(BUSY), .DONE(DONE), .WORD(WORD), .SERIAL_WORD(SERIAL_WORD), .LINK(lnk.host));
    sacs_link_chk sacs_link_chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .start(lnk.start),
        .conv_clk(lnk.conv_clk), .ser_data(lnk.ser_data), .strobe(lnk.strobe),
        .status(lnk.status), .data(lnk.data));

    // ==========================================================
    // Comparator and wire monitor
    always @(posedge CLK) COMP_IN <= #2 (TRIAL <= vin);

    always @(posedge CLK) begin
        cyc <= cyc + 1;
        stb_q <= lnk.strobe;
        clk_q <= lnk.conv_clk;
        if (lnk.start) begin
            nstb <= 0;
            nfall <= 0;
        end else begin
            if (lnk.strobe && !stb_q) begin
                wire_sh <= {wire_sh[8:0], lnk.ser_data};
                nstb <= nstb + 1;
            end
            if (!lnk.conv_clk && clk_q) begin
                nfall <= nfall + 1;
            end
        end
    end

    always @(posedge CLK) begin
        if (cyc == 15000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ==========================================================
    // Tasks
    function automatic logic [9:0] sar_expect(input logic [9:0] v);
        logic [9:0] r;
        r = 10'h000;
        for (int i = 9; i >= 0; i--) begin
            if ((r | (10'h001 << i)) <= v) begin
                r = r | (10'h001 << i);
            end
        end
        return r;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask

    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic run_conv(input logic [9:0] v, input logic hold);
        int n;
        logic [9:0] e;
        e = sar_expect(v);
        vin = v;
        CONVERT = 1'b1;
        n = 0;
        while (BUSY !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        CONVERT = hold;
        n = 0;
        while (DONE !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        check("word", e, WORD);
        check("serial word", e, SERIAL_WORD);
        check("wire bits", e, wire_sh);
        check("link data", e, lnk.data);
        check("status", 10'h001, {9'h000, lnk.status});
        check("strobes", 10'h00A, 10'(nstb));
        check("falls", 10'h00B, 10'(nfall));
        check("clock idle", 10'h001, {9'h000, lnk.conv_clk});
        $display("test code %h done", v);
    endtask

    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [9:0] r;
        r = 10'($urandom(32'hC640));
        tick(10);
        SYS_RST = 1'b0;
        // Frozen host must not take a request
        CE = 1'b0;
        CONVERT = 1'b1;
        tick(5);
        check("busy frozen", 10'h000, {9'h000, BUSY});
        $display("test frozen done");
        CONVERT = 1'b0;
        CE = 1'b1;
        tick(1);
        foreach (corners[i]) begin
            run_conv(corners[i], 1'b0);
        end
        // Back to back requests
        run_conv(10'($urandom), 1'b1);
        run_conv(10'($urandom), 1'b1);
        run_conv(r, 1'b0);
        repeat (6) run_conv(10'($urandom), 1'b0);
        // Reset in mid conversion
        CONVERT = 1'b1;
        tick(2);
        CONVERT = 1'b0;
        tick(200);
        SYS_RST = 1'b1;
        tick(2);
        SYS_RST = 1'b0;
        tick(1);
        check("status reset", 10'h000, {9'h000, lnk.status});
        check("data reset", 10'h000, lnk.data);
        check("busy reset", 10'h000, {9'h000, BUSY});
        $display("test reset done");
        run_conv(10'h155, 1'b0);
        give_verdict();
    end
endmodule
